//--- core/plrt_core.sv
// power loss ride-through sequencer: detection, base-block timing, restart.
// assumes all inputs synchronous to clk_in; register port has no wait states.
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module plrt_core
  import plrt_pkg::*;
#(
  parameter int TICK_CYCLES = PLRT_TICK_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        ce_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  input  wire logic [9:0]  dc_bus_volts_in,
  input  wire logic [9:0]  ac_in_volts_in,
  input  wire logic [7:0]  freq_dev_in,
  input  wire logic        ctrl_supply_ok_in,
  input  wire logic        run_cmd_in,
  input  wire logic        search_done_in,
  output logic             base_block_out,
  output logic             run_enable_out,
  output logic             speed_search_out,
  output logic             volt_ramp_out,
  output logic      [8:0]  ramp_step_out,
  output logic             power_loss_out,
  output logic             fault_out,
  output logic      [1:0]  fault_code_out
);

  // ==========================================================================
  // state and helpers
  plrt_core_t  r;
  plrt_core_t  s;
  logic        tick;
  logic        st_tmr_done;
  logic        ride_done;
  logic [8:0]  st_cnt;
  logic [8:0]  st_limit;
  logic        st_clear;
  logic        ride_clear;
  logic [9:0]  dc_eff;
  logic [9:0]  in_eff;
  logic        dc_low;
  logic        ac_low;
  logic        loss;
  logic [15:0] supply_freq_fault_alt_scaled;
  logic [15:0] fwid_scaled;
  logic        freq_bad;
  logic        lost_abort;
  logic        fault_clr;
  logic        active;

  function automatic logic [8:0] clampv(input logic [31:0] v, input logic [8:0] lo, input logic [8:0] hi);
    logic [31:0] t;
    t = v;
    if (t < {23'h00_0000, lo}) begin
      t = {23'h00_0000, lo};
    end else if (t > {23'h00_0000, hi}) begin
      t = {23'h00_0000, hi};
    end
    return t[8:0];
  endfunction

  // ==========================================================================
  // tick and timers
  // common tenth tick
  plrt_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_in      (clk_in),
    .arst_n_in   (arst_n_in),
    .ce_in       (ce_in),
    .tick_out    (tick)
  );

  plrt_tick_timer u_st_tmr (
    .clk_in      (clk_in),
    .arst_n_in   (arst_n_in),
    .ce_in       (ce_in),
    .tick_in     (tick),
    .clear_in    (st_clear),
    .limit_in    (st_limit),
    .count_out   (st_cnt),
    .done_out    (st_tmr_done)
  );

  // outage clock runs only while blocked or waiting for the supply
  plrt_tick_timer u_ride_tmr (
    .clk_in      (clk_in),
    .arst_n_in   (arst_n_in),
    .ce_in       (ce_in),
    .tick_in     (tick),
    .clear_in    (ride_clear),
    .limit_in    (r.ride_t),
    .count_out   (),
    .done_out    (ride_done)
  );

  // ==========================================================================
  // detection
  always_comb begin
    dc_eff = r.hv ? {r.dc_lvl, 1'b0} : {1'b0, r.dc_lvl};
    in_eff = r.hv ? {r.in_lvl, 1'b0} : {1'b0, r.in_lvl};
    dc_low = (dc_bus_volts_in < dc_eff);
    ac_low = (ac_in_volts_in < in_eff);
    loss = dc_low || ac_low;
    supply_freq_fault_alt_scaled = 16'(freq_dev_in) * 16'(r.gain);
    fwid_scaled = 16'(r.fwidth) * PLRT_GAIN_UNIT;
    freq_bad = (supply_freq_fault_alt_scaled > fwid_scaled);
  end

  assign lost_abort = ((r.mode == PLRT_MODE_TIMED) && loss && ride_done) ||
                      ((r.mode == PLRT_MODE_CPU) && !ctrl_supply_ok_in);
  assign fault_clr  = wr_in && (addr_in == PLRT_OFS_CTRL) && wdata_in[PLRT_CTRL_CLR_BIT];

  always_comb begin
    case (r.st)
      PLRT_ST_BLOCK: st_limit = r.minbb_t;
      PLRT_ST_DELAY: st_limit = r.dly_t;
      PLRT_ST_RESON: st_limit = r.reson_t;
      PLRT_ST_RAMP:  st_limit = r.ramp_t;
      default:       st_limit = 9'h1FF;
    endcase
  end

  // ==========================================================================
  // next state
  always_comb begin
    s = r;
    s.rdata = 32'h0000_0000;
    if (wr_in) begin
      case (addr_in)
        PLRT_OFS_CTRL: begin
          s.mode = (wdata_in[1:0] > PLRT_MODE_CPU) ? PLRT_MODE_CPU : wdata_in[1:0];
          s.hv   = wdata_in[PLRT_CTRL_HV_BIT];
          s.cdet = wdata_in[PLRT_CTRL_CDET_BIT];
        end
        PLRT_OFS_RIDE:   s.ride_t  = clampv(wdata_in, PLRT_ZERO9, PLRT_RIDE_MAX);
        PLRT_OFS_MINBB:  s.minbb_t = clampv(wdata_in, PLRT_MINBB_MIN, PLRT_MINBB_MAX);
        PLRT_OFS_RAMP:   s.ramp_t  = clampv(wdata_in, PLRT_ZERO9, PLRT_RAMP_MAX);
        PLRT_OFS_DLY:    s.dly_t   = clampv(wdata_in, PLRT_ZERO9, PLRT_DLY_MAX);
        PLRT_OFS_RESON:  s.reson_t = clampv(wdata_in, PLRT_ZERO9, PLRT_RESON_MAX);
        PLRT_OFS_DCUV:   s.dc_lvl  = clampv(wdata_in, PLRT_DCUV_MIN, PLRT_DCUV_MAX);
        PLRT_OFS_INUV:   s.in_lvl  = clampv(wdata_in, PLRT_INUV_MIN, PLRT_INUV_MAX);
        PLRT_OFS_FGAIN:  s.gain    = clampv(wdata_in, PLRT_FGAIN_MIN, PLRT_FGAIN_MAX);
        PLRT_OFS_FWIDTH: s.fwidth  = clampv(wdata_in, PLRT_FWID_MIN, PLRT_FWID_MAX);
        default: ;
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        PLRT_OFS_CTRL:   s.rdata = {28'h000_0000, r.cdet, r.hv, r.mode};
        PLRT_OFS_RIDE:   s.rdata = {23'h00_0000, r.ride_t};
        PLRT_OFS_MINBB:  s.rdata = {23'h00_0000, r.minbb_t};
        PLRT_OFS_RAMP:   s.rdata = {23'h00_0000, r.ramp_t};
        PLRT_OFS_DLY:    s.rdata = {23'h00_0000, r.dly_t};
        PLRT_OFS_RESON:  s.rdata = {23'h00_0000, r.reson_t};
        PLRT_OFS_DCUV:   s.rdata = {23'h00_0000, r.dc_lvl};
        PLRT_OFS_INUV:   s.rdata = {23'h00_0000, r.in_lvl};
        PLRT_OFS_FGAIN:  s.rdata = {23'h00_0000, r.gain};
        PLRT_OFS_FWIDTH: s.rdata = {23'h00_0000, r.fwidth};
        PLRT_OFS_STATUS: s.rdata = {19'h0_0000, freq_bad, loss, r.code, r.st};
        default:         s.rdata = 32'h0000_0000;
      endcase
    end

    case (r.st)
      PLRT_ST_IDLE: begin
        if (run_cmd_in && !loss && !freq_bad) begin
          s.st = PLRT_ST_RUN;
        end
      end
      PLRT_ST_RUN: begin
        if (!run_cmd_in) begin
          s.st = PLRT_ST_IDLE;
        end else if (loss) begin
          if (r.mode == PLRT_MODE_TRIP) begin
            s.st   = PLRT_ST_FAULT;
            s.code = PLRT_FLT_FREQ;
          end else begin
            s.st = PLRT_ST_BLOCK;
          end
        end else if (freq_bad) begin
          s.st   = PLRT_ST_FAULT;
          s.code = PLRT_FLT_FREQ;
        end
      end
      PLRT_ST_BLOCK: begin
        if (lost_abort) begin
          s.st   = PLRT_ST_FAULT;
          s.code = PLRT_FLT_UV;
        end else if (st_tmr_done) begin
          s.st = loss ? PLRT_ST_WAIT : PLRT_ST_DELAY;
        end
      end
      PLRT_ST_WAIT: begin
        if (lost_abort) begin
          s.st   = PLRT_ST_FAULT;
          s.code = PLRT_FLT_UV;
        end else if (!loss) begin
          s.st = PLRT_ST_DELAY;
        end
      end
      PLRT_ST_DELAY: begin
        if (loss) begin
          s.st = PLRT_ST_BLOCK;
        end else if (st_tmr_done) begin
          s.st = PLRT_ST_RESON;
        end
      end
      PLRT_ST_RESON: begin
        if (loss) begin
          s.st = PLRT_ST_BLOCK;
        end else if (st_tmr_done) begin
          s.st = PLRT_ST_SEARCH;
        end
      end
      PLRT_ST_SEARCH: begin
        if (loss) begin
          s.st = PLRT_ST_BLOCK;
        end else if (search_done_in) begin
          s.st = r.cdet ? PLRT_ST_RAMP : PLRT_ST_RUN;
        end
      end
      PLRT_ST_RAMP: begin
        if (loss) begin
          s.st = PLRT_ST_BLOCK;
        end else if (st_tmr_done) begin
          s.st = PLRT_ST_RUN;
        end
      end
      PLRT_ST_FAULT: begin
        if (fault_clr) begin
          s.st   = PLRT_ST_IDLE;
          s.code = PLRT_FLT_NONE;
        end
      end
      default: begin
        s.st = PLRT_ST_IDLE;
      end
    endcase
  end

  assign st_clear   = (s.st != r.st);
  assign ride_clear = !((r.st == PLRT_ST_BLOCK) || (r.st == PLRT_ST_WAIT));

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r <= PLRT_CORE_RST;
    end else if (ce_in) begin
      r <= s;
    end
  end

  // ==========================================================================
  // outputs
  assign active = (r.st == PLRT_ST_RUN) || (r.st == PLRT_ST_SEARCH) || (r.st == PLRT_ST_RAMP);
  assign base_block_out   = !active;
  assign run_enable_out   = active;
  assign speed_search_out = (r.st == PLRT_ST_SEARCH);
  assign volt_ramp_out    = (r.st == PLRT_ST_RAMP);
  assign ramp_step_out    = st_cnt;
  assign power_loss_out   = loss;
  assign fault_out        = (r.st == PLRT_ST_FAULT);
  assign fault_code_out   = r.code;
  assign rdata_out        = r.rdata;

  // ==========================================================================
  // checks
  property p_trip_mode0;
    @(posedge clk_in) disable iff (!arst_n_in)
    (ce_in && r.st == PLRT_ST_RUN && run_cmd_in && loss && r.mode == PLRT_MODE_TRIP)
      |=> (fault_out && fault_code_out == PLRT_FLT_FREQ);
  endproperty
  a_trip_mode0: assert property (p_trip_mode0) else $error("mode 0 loss did not trip");

  property p_timed_restart;
    @(posedge clk_in) disable iff (!arst_n_in)
    (ce_in && r.st == PLRT_ST_WAIT && r.mode == PLRT_MODE_TIMED && !loss)
      |=> (r.st == PLRT_ST_DELAY) ##1 (base_block_out && !fault_out);
  endproperty
  a_timed_restart: assert property (p_timed_restart) else $error("timed restart missed");

  property p_timeout_fault;
    @(posedge clk_in) disable iff (!arst_n_in)
    (ce_in && (r.st == PLRT_ST_BLOCK || r.st == PLRT_ST_WAIT) && r.mode == PLRT_MODE_TIMED && loss && ride_done)
      |=> (fault_out && fault_code_out == PLRT_FLT_UV && !run_enable_out);
  endproperty
  a_timeout_fault: assert property (p_timeout_fault) else $error("outage timeout not faulted");

  property p_cpu_no_fault;
    @(posedge clk_in) disable iff (!arst_n_in)
    (ce_in && r.st == PLRT_ST_RUN && run_cmd_in && loss && r.mode == PLRT_MODE_CPU)
      |=> (r.st == PLRT_ST_BLOCK && !fault_out);
  endproperty
  a_cpu_no_fault: assert property (p_cpu_no_fault) else $error("mode 2 loss raised fault");

  property p_min_block;
    @(posedge clk_in) disable iff (!arst_n_in)
    (ce_in && r.st == PLRT_ST_BLOCK && st_cnt < r.minbb_t)
      |=> (base_block_out);
  endproperty
  a_min_block: assert property (p_min_block) else $error("block released early");

  property p_fault_quiet;
    @(posedge clk_in) disable iff (!arst_n_in)
    (r.st != PLRT_ST_FAULT) |-> (!fault_out && (r.st == PLRT_ST_IDLE || r.st == PLRT_ST_RUN
      || fault_code_out == PLRT_FLT_NONE));
  endproperty
  a_fault_quiet: assert property (p_fault_quiet) else $error("fault shown during recovery");

  property p_block_no_drive;
    @(posedge clk_in) disable iff (!arst_n_in)
    $rose(base_block_out) |-> (!run_enable_out && !speed_search_out && !volt_ramp_out);
  endproperty
  a_block_no_drive: assert property (p_block_no_drive) else $error("output driven in block");

  property p_seq_order;
    @(posedge clk_in) disable iff (!arst_n_in)
    (ce_in && r.st == PLRT_ST_RESON && !loss && st_tmr_done)
      |=> (speed_search_out && run_enable_out);
  endproperty
  a_seq_order: assert property (p_seq_order) else $error("search not after resonance");

  property p_hv_double;
    @(posedge clk_in) disable iff (!arst_n_in)
    (r.hv && (dc_bus_volts_in >= {1'b0, r.dc_lvl})
      && (dc_bus_volts_in < {r.dc_lvl, 1'b0}))
      |-> power_loss_out;
  endproperty
  a_hv_double: assert property (p_hv_double) else $error("high class threshold wrong");

  property p_freq_trip;
    @(posedge clk_in) disable iff (!arst_n_in)
    (ce_in && r.st == PLRT_ST_RUN && run_cmd_in && !loss
      && (16'(freq_dev_in) * 16'(r.gain)) > (16'(r.fwidth) * PLRT_GAIN_UNIT))
      |=> (fault_code_out == PLRT_FLT_FREQ);
  endproperty
  a_freq_trip: assert property (p_freq_trip) else $error("frequency fault missed");

endmodule
`default_nettype wire

//--- core/plrt_pkg.sv
// package for the power loss ride-through sequencer: timing, register map,
// reset values, setting ranges, fault codes and state encodings.
// assumes a 100 MHz control clock; all time settings are tenths of a second.
package plrt_pkg;

  // ==========================================================================
  // timing
  localparam int PLRT_CLK_PERIOD_NS = 10;
  localparam int PLRT_TICK_NS       = 100_000_000;
  localparam int PLRT_TICK_CYCLES   = PLRT_TICK_NS / PLRT_CLK_PERIOD_NS;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] PLRT_OFS_CTRL   = 8'h00;
  localparam logic [7:0] PLRT_OFS_RIDE   = 8'h04;
  localparam logic [7:0] PLRT_OFS_MINBB  = 8'h08;
  localparam logic [7:0] PLRT_OFS_RAMP   = 8'h0C;
  localparam logic [7:0] PLRT_OFS_DLY    = 8'h10;
  localparam logic [7:0] PLRT_OFS_RESON  = 8'h14;
  localparam logic [7:0] PLRT_OFS_DCUV   = 8'h18;
  localparam logic [7:0] PLRT_OFS_INUV   = 8'h1C;
  localparam logic [7:0] PLRT_OFS_FGAIN  = 8'h20;
  localparam logic [7:0] PLRT_OFS_FWIDTH = 8'h24;
  localparam logic [7:0] PLRT_OFS_STATUS = 8'h28;

  // control field positions
  localparam int PLRT_CTRL_MODE_LSB = 0;
  localparam int PLRT_CTRL_HV_BIT   = 2;
  localparam int PLRT_CTRL_CDET_BIT = 3;
  localparam int PLRT_CTRL_CLR_BIT  = 4;

  // ==========================================================================
  // modes and fault codes
  localparam logic [1:0] PLRT_MODE_TRIP  = 2'h0;
  localparam logic [1:0] PLRT_MODE_TIMED = 2'h1;
  localparam logic [1:0] PLRT_MODE_CPU   = 2'h2;
  localparam logic [1:0] PLRT_FLT_NONE   = 2'h0;
  localparam logic [1:0] PLRT_FLT_FREQ   = 2'h1;
  localparam logic [1:0] PLRT_FLT_UV     = 2'h2;

  // ==========================================================================
  // settings: reset values and ranges (volts, tenths of s, tenths of Hz)
  localparam logic [8:0] PLRT_RIDE_RST  = 9'h005;
  localparam logic [8:0] PLRT_RIDE_MAX  = 9'h019;
  localparam logic [8:0] PLRT_MINBB_RST = 9'h007;
  localparam logic [8:0] PLRT_MINBB_MIN = 9'h001;
  localparam logic [8:0] PLRT_MINBB_MAX = 9'h032;
  localparam logic [8:0] PLRT_RAMP_RST  = 9'h00F;
  localparam logic [8:0] PLRT_RAMP_MAX  = 9'h032;
  localparam logic [8:0] PLRT_DLY_RST   = 9'h002;
  localparam logic [8:0] PLRT_DLY_MAX   = 9'h0C8;
  localparam logic [8:0] PLRT_RESON_RST = 9'h001;
  localparam logic [8:0] PLRT_RESON_MAX = 9'h032;
  localparam logic [8:0] PLRT_DCUV_RST  = 9'h0BE;
  localparam logic [8:0] PLRT_DCUV_MIN  = 9'h096;
  localparam logic [8:0] PLRT_DCUV_MAX  = 9'h0D2;
  localparam logic [8:0] PLRT_INUV_RST  = 9'h096;
  localparam logic [8:0] PLRT_INUV_MIN  = 9'h064;
  localparam logic [8:0] PLRT_INUV_MAX  = 9'h0C8;
  localparam logic [8:0] PLRT_FGAIN_RST = 9'h00A;
  localparam logic [8:0] PLRT_FGAIN_MIN = 9'h001;
  localparam logic [8:0] PLRT_FGAIN_MAX = 9'h014;
  localparam logic [8:0] PLRT_FWID_RST  = 9'h03C;
  localparam logic [8:0] PLRT_FWID_MIN  = 9'h01E;
  localparam logic [8:0] PLRT_FWID_MAX  = 9'h0C8;
  localparam logic [8:0] PLRT_ZERO9     = 9'h000;
  localparam logic [15:0] PLRT_GAIN_UNIT = 16'h000A;

  // ==========================================================================
  // sequencer states, one-hot
  typedef enum logic [8:0] {
    PLRT_ST_IDLE   = 9'h001,
    PLRT_ST_RUN    = 9'h002,
    PLRT_ST_BLOCK  = 9'h004,
    PLRT_ST_WAIT   = 9'h008,
    PLRT_ST_DELAY  = 9'h010,
    PLRT_ST_RESON  = 9'h020,
    PLRT_ST_SEARCH = 9'h040,
    PLRT_ST_RAMP   = 9'h080,
    PLRT_ST_FAULT  = 9'h100
  } plrt_state_t;

  typedef struct packed {
    plrt_state_t st;
    logic [1:0]  code;
    logic [1:0]  mode;
    logic        hv;
    logic        cdet;
    logic [8:0]  ride_t;
    logic [8:0]  minbb_t;
    logic [8:0]  ramp_t;
    logic [8:0]  dly_t;
    logic [8:0]  reson_t;
    logic [8:0]  dc_lvl;
    logic [8:0]  in_lvl;
    logic [8:0]  gain;
    logic [8:0]  fwidth;
    logic [31:0] rdata;
  } plrt_core_t;

  localparam plrt_core_t PLRT_CORE_RST = '{
    st: PLRT_ST_IDLE, code: PLRT_FLT_NONE, mode: PLRT_MODE_TRIP, hv: 1'b0, cdet: 1'b0,
    ride_t: PLRT_RIDE_RST, minbb_t: PLRT_MINBB_RST, ramp_t: PLRT_RAMP_RST,
    dly_t: PLRT_DLY_RST, reson_t: PLRT_RESON_RST, dc_lvl: PLRT_DCUV_RST,
    in_lvl: PLRT_INUV_RST, gain: PLRT_FGAIN_RST, fwidth: PLRT_FWID_RST,
    rdata: 32'h0000_0000};

endpackage

//--- core/plrt_tick_gen.sv
// common 0.1 s tick for all sequencer timers.
// assumes clk_in at the rate the package states; ce_in low freezes the count.
`timescale 1ns/100ps
`default_nettype none
module plrt_tick_gen
  import plrt_pkg::*;
#(
  parameter int TICK_CYCLES = PLRT_TICK_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic ce_in,
  output logic      tick_out
);
  localparam int CW = $clog2(TICK_CYCLES);

  if (TICK_CYCLES < 2) begin : g_chk
    $error("tick period must be at least two cycles");
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } plrt_tgen_t;

  plrt_tgen_t r;
  plrt_tgen_t s;

  always_comb begin
    s = r;
    s.tick = 1'b0;
    if (r.cnt == CW'(TICK_CYCLES - 1)) begin
      s.cnt  = '0;
      s.tick = 1'b1;
    end else begin
      s.cnt = r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= s;
    end
  end

  assign tick_out = r.tick;
endmodule
`default_nettype wire

//--- core/plrt_tick_timer.sv
// saturating tick counter with synchronous clear and a reach flag.
// assumes tick_in is a one-cycle pulse; clear wins over a tick.
`timescale 1ns/100ps
`default_nettype none
module plrt_tick_timer
  import plrt_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       ce_in,
  input  wire logic       tick_in,
  input  wire logic       clear_in,
  input  wire logic [8:0] limit_in,
  output logic      [8:0] count_out,
  output logic            done_out
);
  typedef struct packed {
    logic [8:0] cnt;
  } plrt_tmr_t;

  plrt_tmr_t r;
  plrt_tmr_t s;

  always_comb begin
    s = r;
    if (clear_in) begin
      s.cnt = PLRT_ZERO9;
    end else if (tick_in && (r.cnt != 9'h1FF)) begin
      s.cnt = r.cnt + 9'h001;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= s;
    end
  end

  assign count_out = r.cnt;
  assign done_out  = (r.cnt >= limit_in);
endmodule
`default_nettype wire

//--- testbench/plrt_mains_model.sv
// model of mains monitor and output stage for the sequencer bench.
// assumes drop_in from the bench; search answer after SRCH_LAT cycles.
`timescale 1ns/100ps
`default_nettype none
module plrt_mains_model #(
  parameter int SRCH_LAT = 3
) (
  input  wire logic       clk_in,
  input  wire logic [1:0] drop_in,
  input  wire logic       search_in,
  output logic      [9:0] dc_out,
  output logic      [9:0] ac_out,
  output logic            done_out
);
  int cnt = 0;
  // ==========================================================================
  // supply levels, nominal sits above both low-class thresholds
  assign dc_out = drop_in[0] ? 10'h064 : 10'h118;
  assign ac_out = drop_in[1] ? 10'h050 : 10'h0DC;
  // search answer is late on purpose, never at once
  always @(posedge clk_in) begin
    cnt <= search_in ? cnt + 1 : 0;
  end
  assign done_out = (cnt >= SRCH_LAT);
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench for the ride-through sequencer.
// assumes a short tick of T cycles; the bench keeps run commands latched.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import plrt_pkg::*;
  localparam int T = 4;
  typedef struct {logic [7:0] a; logic [15:0] v;} plrt_row_t;
  logic        clk_in = 0, arst_n_in = 0, wr = 0, rd = 0, run = 0, cok = 1, ce = 1, sdone;
  logic [7:0]  addr = 0, supply_freq_fault_alt = 0;
  logic [31:0] wd = 0, rdata, g;
  logic [1:0]  drop = 0, fcode;
  logic [9:0]  dcv, acv;
  logic [8:0]  rstep;
  logic        bb, rena, srch, ramp, loss, flt;
  logic [4:0]  sv;
  int          num_errors = 0, check_count = 0, n;
  longint      t0;
  plrt_row_t rows [11] = '{'{8'h04, 16'h0005}, '{8'h08, 16'h0007}, '{8'h0C, 16'h000F},
    '{8'h10, 16'h0002}, '{8'h14, 16'h0001}, '{8'h18, 16'h00BE}, '{8'h1C, 16'h0096},
    '{8'h20, 16'h000A}, '{8'h24, 16'h003C}, '{8'h28, 16'h0001}, '{8'h2C, 16'h0000}};
  assign sv = {ramp, flt, srch, bb, rena};
  always #5 clk_in = ~clk_in;
  plrt_core #(.TICK_CYCLES(T)) i_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(ce),
    .addr_in(addr), .wdata_in(wd), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .dc_bus_volts_in(dcv), .ac_in_volts_in(acv), .freq_dev_in(supply_freq_fault_alt),
    .ctrl_supply_ok_in(cok), .run_cmd_in(run), .search_done_in(sdone),
    .base_block_out(bb), .run_enable_out(rena), .speed_search_out(srch),
    .volt_ramp_out(ramp), .ramp_step_out(rstep), .power_loss_out(loss),
    .fault_out(flt), .fault_code_out(fcode));
  plrt_mains_model i_mains (.clk_in(clk_in), .drop_in(drop), .search_in(srch),
    .dc_out(dcv), .ac_out(acv), .done_out(sdone));
  // ==========================================================================
  // tasks
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
    check_count++;
    if (v !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", s, e, v);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk_in);
  endtask
  // bounded wait; running out counts as a mismatch
  task automatic wt(input int k, input logic v);
    #1;
    for (n = 0; n < 600 && sv[k] !== v; n++) begin
      @(posedge clk_in);
      #1;
    end
    if (sv[k] !== v) begin
      num_errors++;
      $display("mismatch wait_sv%0d expected %b seen %b", k, v, sv[k]);
    end
    @(posedge clk_in);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  initial begin
    repeat (12) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    chk("bb", 1, bb);
    foreach (rows[i]) begin
      rreg(rows[i].a, g);
      chk("reg", {16'h0000, rows[i].v}, g);
    end
    wreg(8'h04, 32'h0000_0063);
    rreg(8'h04, g);
    chk("ride", 32'h0000_0019, g);
    wreg(8'h00, 32'h0000_0004);
    chk("loss_hv", 1, loss);
    wreg(8'h00, 32'h0000_0000);
    drop <= 2'h2;
    @(posedge clk_in);
    chk("loss_ac", 1, loss);
    drop <= 2'h0;
    run <= 1'b1;
    wt(0, 1);
    drop <= 2'h1;
    wt(3, 1);
    drop <= 2'h0;
    repeat (30) @(posedge clk_in);
    chk("m0", 32'h8100_0001, {flt, 6'h00, bb, 22'h0, fcode});
    run <= 1'b0;
    wreg(8'h00, 32'h0000_0010);
    run <= 1'b1;
    wt(0, 1);
    supply_freq_fault_alt <= 8'h3D;
    wt(3, 1);
    chk("freq", 2'h1, fcode);
    supply_freq_fault_alt <= 8'h00;
    run <= 1'b0;
    wreg(8'h00, 32'h0000_0019);
    wreg(8'h04, 32'h0000_0005);
    wreg(8'h08, 32'h0000_000A);
    run <= 1'b1;
    wt(0, 1);
    drop <= 2'h1;
    wt(1, 1);
    t0 = $time;
    repeat (5) @(posedge clk_in);
    drop <= 2'h0;
    wt(2, 1);
    chk("bb_len", 1, ($time - t0) >= 380);
    chk("recov", 2'h0, {flt, bb});
    wt(4, 1);
    t0 = $time;
    repeat (8 * T) @(posedge clk_in);
    chk("rstep", 32'h0000_0008, rstep);
    wt(4, 0);
    chk("ramp_len", 1, ($time - t0) >= 540);
    rreg(8'h28, g);
    chk("status", 32'h0000_0002, g);
    wreg(8'h08, 32'h0000_0001);
    wreg(8'h04, 32'h0000_0019);
    drop <= 2'h1;
    wt(1, 1);
    repeat (20) @(posedge clk_in);
    rreg(8'h28, g);
    chk("m1_wait", 32'h0000_0808, g);
    drop <= 2'h0;
    wt(2, 1);
    chk("m1_srch", 1'b0, flt);
    wt(4, 1);
    wt(4, 0);
    chk("m1_run", 1'b1, rena);
    wreg(8'h04, 32'h0000_0001);
    drop <= 2'h1;
    wt(3, 1);
    chk("ride_out", 2'h2, fcode);
    drop <= 2'h0;
    run <= 1'b0;
    wreg(8'h00, 32'h0000_0012);
    run <= 1'b1;
    wt(0, 1);
    drop <= 2'h1;
    wt(1, 1);
    repeat (60) @(posedge clk_in);
    drop <= 2'h0;
    wt(2, 1);
    chk("m2", 1'b0, flt);
    wt(2, 0);
    chk("m2_run", 1'b1, rena);
    drop <= 2'h1;
    cok <= 1'b0;
    wt(3, 1);
    chk("m2_cpu", 2'h2, fcode);
    ce <= 1'b0;
    wreg(8'h00, 32'h0000_0010);
    ce <= 1'b1;
    @(posedge clk_in);
    chk("ce_hold", 1'b1, flt);
    arst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    chk("rst_out", 32'h0000_0001, {flt, fcode, rstep, bb});
    rreg(8'h04, g);
    chk("rst_ride", 32'h0000_0005, g);
    complete_run();
  end
  initial begin
    #300000;
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
